// *** common/iesc_pkg.sv ***
// iesc_pkg: shared constants and carrier types for the implicit error sync control
// assumes: single core clock domain, register port in the pipeline's control unit
package iesc_pkg;

  // register offsets (word addresses on the plain register port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;
  localparam logic [3:0] REG_SYND = 4'h4;
  localparam logic [3:0] REG_RADDR = 4'h5;
  localparam logic [3:0] REG_DEFREC = 4'h6;
  localparam logic [3:0] REG_VDEFREC = 4'h7;

  // control register fields
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_AARCH_LSB = 3;
  localparam int CTRL_DFAULT_BIT = 6;
  localparam int CTRL_NMEA_BIT = 7;
  localparam int CTRL_EARLY_BIT = 8;
  localparam int CTRL_RETFLAG_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status / mask event bits
  localparam int EV_SYNC = 0;
  localparam int EV_TAKEN = 1;
  localparam int EV_PEND = 2;
  localparam int EV_W = 3;

  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    IESC_EL0 = 2'b00,
    IESC_EL1 = 2'b01,
    IESC_EL2 = 2'b10,
    IESC_EL3 = 2'b11
  } iesc_el_e;

  typedef enum logic [2:0] {
    IESC_K_NONE = 3'b000,
    IESC_K_EXC = 3'b001,
    IESC_K_DCL = 3'b010,
    IESC_K_RET = 3'b011,
    IESC_K_DRS = 3'b100
  } iesc_kind_e;

  // one pipeline request to this block
  typedef struct packed {
    logic valid;
    iesc_kind_e kind;
    iesc_el_e target;
    logic raises_exc;
    logic illegal_ret;
    logic debug_state;
    logic [31:0] vec_addr;
    logic [31:0] instr_addr;
  } iesc_req_s;

  // answer to the pipeline, one cycle after a request
  typedef struct packed {
    logic done;
    logic sync_evt;
    logic serr_taken;
    logic terminate;
    logic replace_exc;
    logic syn_flag;
    logic set_illegal;
    logic [31:0] ret_addr;
  } iesc_rsp_s;

endpackage : iesc_pkg

// *** hdl/iesc_regs.sv ***
// iesc_regs: small record store for the two deferred error records
// assumes: written only by software, never by the sync logic
`timescale 1ns/1ps
`default_nettype none
module iesc_regs #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // access
  input wire logic wr_i,
  input wire logic sel_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic rsel_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] nxt_rdata;

  always_comb
  begin
    nxt_mem[0] = mem_ff[0];
    nxt_mem[1] = mem_ff[1];
    if (wr_i)
    begin
      nxt_mem[sel_i] = wdata_i;
    end
    nxt_rdata = mem_ff[rsel_i];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

endmodule // iesc_regs
`default_nettype wire

// *** hdl/iesc_ctrl.sv ***
// iesc_ctrl: implicit error sync insertion on exception entry, return and debug level changes
// assumes: pipeline presents one request per cycle at most and an error-pending level
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - double fault forces top enable, with or without nonmaskable abort
// - implicit sync never touches deferred records
// - exceptions to enabled 64-bit level sync
// - debug change-level instruction syncs when enabled
// - entry error sets flag, returns vector
// - masked error stays pending, not recorded
// - optional early take, flag zero
// - sync before entering top level when enabled or on double fault
// - clean exception return syncs when enabled
// - illegal return sets flag, counts clean
// - debug restore-state instruction syncs when enabled
// - error on return terminates that return
// - return error: chosen flag, own address
// - unmasked pending error taken before completion
module iesc_ctrl (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // pipeline request and answer
  input wire iesc_pkg::iesc_req_s req_i,
  input wire logic serr_pending_i,
  input wire logic serr_masked_i,
  output iesc_pkg::iesc_rsp_s rsp_o,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // interrupt
  output logic irq_o
);

  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [iesc_pkg::EV_W-1:0] status_ff;
  logic [iesc_pkg::EV_W-1:0] nxt_status;
  logic [iesc_pkg::EV_W-1:0] mask_ff;
  logic [iesc_pkg::EV_W-1:0] nxt_mask;
  logic pend_ff;
  logic nxt_pend;
  logic syn_ff;
  logic nxt_syn;
  logic [31:0] raddr_ff;
  logic [31:0] nxt_raddr;
  iesc_pkg::iesc_rsp_s rsp_ff;
  iesc_pkg::iesc_rsp_s nxt_rsp;
  logic irq_ff;
  logic nxt_irq;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rd_rec_ff;
  logic nxt_rd_rec;
  logic [31:0] rec_rdata;
  logic rec_wr;

  // effective per-level enable
  function automatic logic eff_enable(input logic [31:0] c, input iesc_pkg::iesc_el_e el);
    logic en;
    en = 1'b0;
    if (el != iesc_pkg::IESC_EL0)
    begin
      en = c[iesc_pkg::CTRL_EN_LSB + int'(el) - 1] & c[iesc_pkg::CTRL_AARCH_LSB + int'(el) - 1];
      if (el == iesc_pkg::IESC_EL3 && c[iesc_pkg::CTRL_DFAULT_BIT])
      begin
        if (c[iesc_pkg::CTRL_NMEA_BIT])
        begin
          en = c[iesc_pkg::CTRL_AARCH_LSB + 2];
        end
        en = en | c[iesc_pkg::CTRL_AARCH_LSB + 2];
      end
    end
    return en;
  endfunction

  // deferred records live apart and are only written by software
  assign rec_wr = reg_wr_i && (reg_addr_i == iesc_pkg::REG_DEFREC || reg_addr_i == iesc_pkg::REG_VDEFREC);

  iesc_regs #(
    .WIDTH(32)
  ) u_rec (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .wr_i(rec_wr),
    .sel_i(reg_addr_i == iesc_pkg::REG_VDEFREC),
    .wdata_i(reg_wdata_i),
    .rsel_i(reg_addr_i == iesc_pkg::REG_VDEFREC),
    .rdata_o(rec_rdata)
  );

  always_comb
  begin
    logic sync;
    logic entry;
    logic retn;
    logic take;
    logic early;
    logic [iesc_pkg::EV_W-1:0] ev;
    sync = 1'b0;
    entry = 1'b0;
    retn = 1'b0;
    take = 1'b0;
    early = 1'b0;
    ev = '0;
    nxt_rsp = '0;
    nxt_pend = pend_ff;
    nxt_syn = syn_ff;
    nxt_raddr = raddr_ff;
    if (req_i.valid)
    begin
      unique case (req_i.kind)
        iesc_pkg::IESC_K_EXC:
        begin
          entry = 1'b1;
          sync = eff_enable(ctrl_ff, req_i.target);
        end
        iesc_pkg::IESC_K_DCL:
        begin
          entry = 1'b1;
          sync = req_i.debug_state && eff_enable(ctrl_ff, req_i.target);
        end
        iesc_pkg::IESC_K_RET:
        begin
          retn = 1'b1;
          // illegal return raises nothing itself
          sync = !req_i.raises_exc && eff_enable(ctrl_ff, req_i.target);
          nxt_rsp.set_illegal = req_i.illegal_ret && !req_i.raises_exc;
        end
        iesc_pkg::IESC_K_DRS:
        begin
          retn = 1'b1;
          sync = req_i.debug_state && !req_i.raises_exc && eff_enable(ctrl_ff, req_i.target);
        end
        default:
        begin
          sync = 1'b0;
        end
      endcase
      nxt_rsp.done = 1'b1;
      nxt_rsp.sync_evt = sync;
      // early take swaps the error in for the exception itself
      early = entry && ctrl_ff[iesc_pkg::CTRL_EARLY_BIT] && serr_pending_i && !serr_masked_i;
      take = sync && (serr_pending_i || pend_ff) && !serr_masked_i;
      if (early)
      begin
        nxt_rsp.serr_taken = 1'b1;
        nxt_rsp.replace_exc = 1'b1;
        nxt_rsp.syn_flag = 1'b0;
        nxt_rsp.ret_addr = req_i.instr_addr;
        nxt_rsp.sync_evt = 1'b0;
      end
      else if (take && entry)
      begin
        nxt_rsp.serr_taken = 1'b1;
        nxt_rsp.syn_flag = 1'b1;
        nxt_rsp.ret_addr = req_i.vec_addr;
      end
      else if (take && retn)
      begin
        nxt_rsp.serr_taken = 1'b1;
        nxt_rsp.terminate = 1'b1;
        nxt_rsp.set_illegal = 1'b0;
        nxt_rsp.syn_flag = ctrl_ff[iesc_pkg::CTRL_RETFLAG_BIT];
        nxt_rsp.ret_addr = req_i.instr_addr;
      end
      if (nxt_rsp.serr_taken)
      begin
        nxt_pend = 1'b0;
        nxt_syn = nxt_rsp.syn_flag;
        nxt_raddr = nxt_rsp.ret_addr;
      end
      else if (sync && serr_pending_i && serr_masked_i)
      begin
        nxt_pend = 1'b1;
      end
    end
    ev[iesc_pkg::EV_SYNC] = nxt_rsp.sync_evt;
    ev[iesc_pkg::EV_TAKEN] = nxt_rsp.serr_taken;
    ev[iesc_pkg::EV_PEND] = nxt_pend && !pend_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        iesc_pkg::REG_CTRL: nxt_ctrl = reg_wdata_i;
        iesc_pkg::REG_MASK: nxt_mask = reg_wdata_i[iesc_pkg::EV_W-1:0];
        iesc_pkg::REG_STATUS: nxt_status = status_ff & ~reg_wdata_i[iesc_pkg::EV_W-1:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    // set wins over a simultaneous clear
    nxt_status = nxt_status | ev;
    nxt_irq = |(nxt_status & mask_ff);
    nxt_rd_rec = reg_rd_i && (reg_addr_i == iesc_pkg::REG_DEFREC || reg_addr_i == iesc_pkg::REG_VDEFREC);
    nxt_rdata = iesc_pkg::RD_UNMAPPED;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        iesc_pkg::REG_CTRL: nxt_rdata = ctrl_ff;
        iesc_pkg::REG_STATUS: nxt_rdata = {{(32-iesc_pkg::EV_W){1'b0}}, status_ff};
        iesc_pkg::REG_MASK: nxt_rdata = {{(32-iesc_pkg::EV_W){1'b0}}, mask_ff};
        iesc_pkg::REG_STATE: nxt_rdata = {30'h0000_0000, syn_ff, pend_ff};
        iesc_pkg::REG_RADDR: nxt_rdata = raddr_ff;
        default: nxt_rdata = iesc_pkg::RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_ff <= iesc_pkg::CTRL_RESET;
      status_ff <= '0;
      mask_ff <= '0;
      pend_ff <= 1'b0;
      syn_ff <= 1'b0;
      raddr_ff <= '0;
      rsp_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= '0;
      rd_rec_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      pend_ff <= nxt_pend;
      syn_ff <= nxt_syn;
      raddr_ff <= nxt_raddr;
      rsp_ff <= nxt_rsp;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
      rd_rec_ff <= nxt_rd_rec;
    end
  end

  assign rsp_o = rsp_ff;
  assign irq_o = irq_ff;
  // record reads come from the store's own output register
  assign reg_rdata_o = rd_rec_ff ? rec_rdata : rdata_ff;

endmodule // iesc_ctrl
`default_nettype wire

// *** verification/iesc_ctrl_sva.sv ***
// iesc_ctrl_sva: port-level checks of the implicit sync controller
// assumes: bound onto iesc_ctrl, one core clock domain
`timescale 1ns/1ps
`default_nettype none
module iesc_ctrl_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // pipeline
  input wire iesc_pkg::iesc_req_s req_i,
  input wire logic serr_pending_i,
  input wire logic serr_masked_i,
  input wire iesc_pkg::iesc_rsp_s rsp_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  done_answer_a:
    assert property (req_i.valid |=> rsp_o.done && (!rsp_o.serr_taken || $past(serr_pending_i)))
    else $error("request not answered");
  masked_hold_a:
    assert property (req_i.valid && serr_masked_i |=> !rsp_o.serr_taken)
    else $error("masked error taken");
  el0_quiet_a:
    assert property (req_i.valid && req_i.target == iesc_pkg::IESC_EL0 |=> !rsp_o.sync_evt)
    else $error("sync at lowest level");
  ret_exc_a:
    assert property (req_i.valid && req_i.kind == iesc_pkg::IESC_K_RET && req_i.raises_exc |=> !rsp_o.sync_evt)
    else $error("sync on faulting return");
  dbg_only_a:
    assert property (req_i.valid && req_i.kind == iesc_pkg::IESC_K_DCL && !req_i.debug_state |=> !rsp_o.sync_evt)
    else $error("level change sync outside debug");
  entry_flag_a:
    assert property (req_i.valid && req_i.kind == iesc_pkg::IESC_K_EXC ##1 rsp_o.serr_taken && !rsp_o.replace_exc
      |-> rsp_o.syn_flag && rsp_o.ret_addr == $past(req_i.vec_addr))
    else $error("entry take flag or address wrong");
  ret_term_a:
    assert property (req_i.valid && req_i.kind == iesc_pkg::IESC_K_RET ##1 rsp_o.serr_taken
      |-> rsp_o.terminate && rsp_o.ret_addr == $past(req_i.instr_addr))
    else $error("return take not terminated");
  early_zero_a:
    assert property (rsp_o.replace_exc |-> rsp_o.serr_taken && !rsp_o.syn_flag && !rsp_o.sync_evt)
    else $error("early take flag wrong");
  take_sync_a:
    assert property (rsp_o.serr_taken && !rsp_o.replace_exc |-> rsp_o.sync_evt)
    else $error("take without sync");
  ill_ret_a:
    assert property (req_i.valid && req_i.kind == iesc_pkg::IESC_K_RET && req_i.illegal_ret && !req_i.raises_exc
      ##1 rsp_o.sync_evt && !rsp_o.serr_taken |-> rsp_o.set_illegal)
    else $error("illegal return flag missing");
endmodule // iesc_ctrl_sva

bind iesc_ctrl iesc_ctrl_sva chk_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
  .serr_pending_i(serr_pending_i), .serr_masked_i(serr_masked_i), .rsp_o(rsp_o));
`default_nettype wire

// *** verification/iesc_pipe_model.sv ***
// iesc_pipe_model: pipeline side, one request at a time, catches the answer
// assumes: answer stands in the cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module iesc_pipe_model (
  // clock
  input wire logic core_clk_i,
  // request side
  output iesc_pkg::iesc_req_s req_o,
  output logic pend_o,
  output logic mask_o,
  // answer side
  input wire iesc_pkg::iesc_rsp_s rsp_i
);
  initial
  begin
    req_o = '0;
    pend_o = 1'b0;
    mask_o = 1'b0;
  end
  // f = {raises_exc, illegal_ret, debug_state}
  task automatic issue(input logic [2:0] k, input logic [1:0] el, input logic [2:0] f, input logic p,
    input logic m, output iesc_pkg::iesc_rsp_s r);
    @(posedge core_clk_i);
    req_o <= {1'b1, k, el, f, 32'h0000_1000 + el, 32'h0000_2000 + el};
    pend_o <= p;
    mask_o <= m;
    @(posedge core_clk_i);
    // released fields scrambled so no stale value looks valid
    req_o <= {1'b0, ~req_o[71:0]};
    pend_o <= 1'b0;
    mask_o <= 1'b0;
    #1 r = rsp_i;
  endtask
endmodule // iesc_pipe_model
`default_nettype wire

// *** verification/iesc_ctrl_tb.sv ***
// iesc_ctrl_tb: directed scenarios for the implicit sync controller
// assumes: pipe model drives requests, bench owns the register port
`timescale 1ns/1ps
`default_nettype none
module iesc_ctrl_tb;
  logic core_clk_i;
  logic reset_n_i;
  logic [3:0] a_q;
  logic [31:0] d_q;
  logic wr_q;
  logic rd_q;
  logic [31:0] rdata;
  logic irq;
  logic pend;
  logic mask;
  iesc_pkg::iesc_req_s req;
  iesc_pkg::iesc_rsp_s rsp;
  int failures;
  int n_checks;
  iesc_ctrl dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_i(req), .serr_pending_i(pend),
    .serr_masked_i(mask), .rsp_o(rsp), .reg_addr_i(a_q), .reg_wdata_i(d_q), .reg_wr_i(wr_q),
    .reg_rd_i(rd_q), .reg_rdata_o(rdata), .irq_o(irq));
  iesc_pipe_model pipe_u (.core_clk_i(core_clk_i), .req_o(req), .pend_o(pend), .mask_o(mask), .rsp_i(rsp));
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    a_q <= a;
    d_q <= d;
    wr_q <= 1'b1;
    @(posedge core_clk_i);
    wr_q <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    a_q <= a;
    rd_q <= 1'b1;
    @(posedge core_clk_i);
    rd_q <= 1'b0;
    #1 chk("reg", e, rdata);
  endtask
  // e = {done, sync, taken, term, replace, syn, illegal}
  task automatic rq(input logic [2:0] k, input logic [1:0] el, input logic [2:0] f, input logic p,
    input logic m, input logic [6:0] e, input logic [31:0] a);
    iesc_pkg::iesc_rsp_s r;
    pipe_u.issue(k, el, f, p, m, r);
    chk("rsp", {25'h0, e}, {25'h0, r.done, r.sync_evt, r.serr_taken, r.terminate, r.replace_exc,
      r.syn_flag, r.set_illegal});
    if (e[4])
      chk("addr", a, r.ret_addr);
  endtask
  task automatic s_entry();
    rd(4'h0, 32'h0000_0000);
    wr(4'h6, 32'hA5A5_0001);
    wr(4'h0, 32'h0000_003E);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0000_0000);
    rq(3'h1, 2'h1, 3'h0, 1'b0, 1'b0, 7'h40, 32'h0);
    wr(4'h0, 32'h0000_003F);
    for (int el = 0; el < 4; el++)
      rq(3'h1, el[1:0], 3'h0, 1'b0, 1'b0, (el == 0) ? 7'h40 : 7'h60, 32'h0);
    rq(3'h1, 2'h3, 3'h0, 1'b1, 1'b1, 7'h60, 32'h0);
    rd(4'h3, 32'h0000_0001);
    rq(3'h1, 2'h2, 3'h0, 1'b1, 1'b0, 7'h72, 32'h0000_1002);
    rd(4'h6, 32'hA5A5_0001);
  endtask
  task automatic s_debug();
    rq(3'h2, 2'h1, 3'h1, 1'b0, 1'b0, 7'h60, 32'h0);
    rq(3'h2, 2'h1, 3'h0, 1'b0, 1'b0, 7'h40, 32'h0);
    rq(3'h4, 2'h2, 3'h1, 1'b0, 1'b0, 7'h60, 32'h0);
    rq(3'h4, 2'h2, 3'h5, 1'b0, 1'b0, 7'h40, 32'h0);
  endtask
  task automatic s_ret();
    wr(4'h0, 32'h0000_023F);
    rq(3'h3, 2'h1, 3'h0, 1'b1, 1'b0, 7'h7A, 32'h0000_2001);
    rq(3'h3, 2'h1, 3'h4, 1'b0, 1'b0, 7'h40, 32'h0);
    rq(3'h3, 2'h2, 3'h2, 1'b0, 1'b0, 7'h61, 32'h0);
  endtask
  task automatic s_top();
    // top enable off: the double fault control forces it, abort control or not
    wr(4'h0, 32'h0000_00F8);
    rq(3'h1, 2'h3, 3'h0, 1'b0, 1'b0, 7'h60, 32'h0);
    rq(3'h3, 2'h3, 3'h0, 1'b0, 1'b0, 7'h60, 32'h0);
    rq(3'h1, 2'h2, 3'h0, 1'b0, 1'b0, 7'h40, 32'h0);
    // double fault without the abort control still syncs entry to the top level
    wr(4'h0, 32'h0000_0078);
    rq(3'h1, 2'h3, 3'h0, 1'b0, 1'b0, 7'h60, 32'h0);
  endtask
  task automatic s_early_irq();
    wr(4'h1, 32'h0000_0007);
    wr(4'h2, 32'h0000_0002);
    wr(4'h0, 32'h0000_013F);
    rq(3'h1, 2'h1, 3'h0, 1'b1, 1'b0, 7'h54, 32'h0000_2001);
    @(posedge core_clk_i);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wr(4'h1, 32'h0000_0002);
    @(posedge core_clk_i);
    #1 chk("irq", 32'h0, {31'h0, irq});
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end
  initial
  begin
    failures = 0;
    n_checks = 0;
    reset_n_i = 1'b0;
    a_q = 4'h0;
    d_q = 32'h0;
    wr_q = 1'b0;
    rd_q = 1'b0;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    s_entry();
    s_debug();
    s_ret();
    s_top();
    s_early_irq();
    print_verdict();
  end
endmodule // iesc_ctrl_tb
`default_nettype wire
